// ---- common/obrd_pkg.sv ----
package obrd_pkg;
	// ***************************************************************
	// enable bit positions
	// ***************************************************************
	localparam int SYS_GLOBAL_EN_BIT = 2;
	localparam int PER_FIRST_CAN_CONTROLLER_BIT = 0;
	localparam int PER_SECOND_CAN_CONTROLLER_BIT = 1;
	localparam int PER_SMALL_EXTENSION_RAM_BIT = 2;
	localparam int PER_LARGE_EXTENSION_RAM_BIT = 3;
	localparam int PER_RTC_BIT = 4;
	localparam int PER_FLASH_BIT = 5;
	localparam int PER_PWM_BIT = 6;
	localparam int PER_ASC_BIT = 7;
	localparam int PER_SSC_BIT = 8;
	localparam int PER_I2C_BIT = 9;
	localparam int PER_TMR_BIT = 10;

	// ***************************************************************
	// address map (24-bit byte addresses)
	// ***************************************************************
	localparam logic [23:0] FLASH_LO = 24'h090000;
	localparam logic [23:0] FLASH_HI = 24'h0EFFFF;
	localparam logic [23:0] FCTRL_LO = 24'h0E0000;
	localparam logic [23:0] BANK3_LO = 24'h0C0000;
	localparam logic [23:0] RSV_LO = 24'h080000;
	localparam logic [23:0] RSV_HI = 24'h08FFFF;
	localparam logic [23:0] SMALL_EXTENSION_RAM_LO = 24'h00E000;
	localparam logic [23:0] SMALL_EXTENSION_RAM_HI = 24'h00E7FF;
	localparam logic [23:0] LARGE_EXTENSION_RAM_LO = 24'h0F0000;
	localparam logic [23:0] LARGE_EXTENSION_RAM_HI = 24'h0FFFFF;
	localparam logic [23:0] FIRST_CAN_CONTROLLER_LO = 24'h00EF00;
	localparam logic [23:0] FIRST_CAN_CONTROLLER_HI = 24'h00EFFF;
	localparam logic [23:0] SECOND_CAN_CONTROLLER_LO = 24'h00EE00;
	localparam logic [23:0] SECOND_CAN_CONTROLLER_HI = 24'h00EEFF;
	localparam logic [23:0] RTC_LO = 24'h00ED00;
	localparam logic [23:0] RTC_HI = 24'h00EDFF;
	localparam logic [23:0] PWM_LO = 24'h00EC00;
	localparam logic [23:0] PWM_HI = 24'h00ECFF;
	localparam logic [23:0] ASC_LO = 24'h00E900;
	localparam logic [23:0] ASC_HI = 24'h00E9FF;
	localparam logic [23:0] SSC_LO = 24'h00E800;
	localparam logic [23:0] SSC_HI = 24'h00E8FF;
	localparam logic [23:0] I2C_LO = 24'h00EA00;
	localparam logic [23:0] I2C_HI = 24'h00EAFF;
	localparam logic [23:0] TMR_LO = 24'h00EB00;
	localparam logic [23:0] TMR_HI = 24'h00EB7F;

	// ***************************************************************
	// access timing
	// ***************************************************************
	localparam logic [1:0] WS_MEM = 2'h0;
	localparam logic [1:0] WS_PERIPH = 2'h2;
	localparam int FLASH_WS_FREQ_MHZ = 40;
	localparam int SEG_LINES_FULL = 8;
	localparam int SEG_LINES_CAN = 4;

	// target select one-hot code
	typedef enum logic [11:0] {
		OBRD_TGT_NONE = 12'h000,
		OBRD_TGT_EXT = 12'h001,
		OBRD_TGT_FLASH = 12'h002,
		OBRD_TGT_SMALL_EXTENSION_RAM = 12'h004,
		OBRD_TGT_LARGE_EXTENSION_RAM = 12'h008,
		OBRD_TGT_FIRST_CAN_CONTROLLER = 12'h010,
		OBRD_TGT_SECOND_CAN_CONTROLLER = 12'h020,
		OBRD_TGT_RTC = 12'h040,
		OBRD_TGT_PWM = 12'h080,
		OBRD_TGT_ASC = 12'h100,
		OBRD_TGT_SSC = 12'h200,
		OBRD_TGT_I2C = 12'h400,
		OBRD_TGT_TMR = 12'h800
	} obrd_tgt_t;
endpackage : obrd_pkg

// ---- core/obrd_decoder.sv ----
`timescale 1ns/1ps
// What this block does
// R1 - flash window needs global and flash enable
// R2 - global off sends flash range external
// R3 - control regs at 0E page; else no program
// R4 - five flash blocks; bank2 three, bank3 two
// R5 - no read in bank being written
// R6 - software sets flash waitstate by clock; flash accesses here always get WS_MEM, whatever the clock
// R7 - 08 segment reserved, no external access while flash or large RAM is mapped
// R8 - ext RAMs single cycle, byte or word
// R9 - small RAM mapped with global and bit2
// R10 - large RAM mapped with global and bit3
// R11 - large RAM off sends range external
// R12 - ext RAM not stack, registers, bit space
// R13 - first CAN with global and bit0
// R14 - second CAN with global and bit1
// R15 - RTC with global and bit4
// R16 - extra PWM with global and bit6
// R17 - second async serial with bit7
// R18 - second sync serial with bit8
// R19 - I2C with global and bit9
// R20 - timer and misc with bit10
// R21 - peripherals word only, two waitstates
// R22 - CAN in use limits segment lines four
// R23 - disabled peripheral occupies nothing
// R24 - on-chip hit suppresses external cycle
module obrd_decoder #(
	parameter int ADDR_W = 24
) (
	input wire logic CLK, // cpu clock
	input wire logic RESETN, // synchronous reset, active low
	input wire logic [15:0] SYSTEM_CONFIG_REG, // system configuration word
	input wire logic [15:0] PERIPH_ENABLE_CONFIG_REG, // peripheral enables
	input wire logic REQ_VALID, // cpu access request
	input wire logic [ADDR_W-1:0] REQ_ADDR, // byte address
	input wire logic REQ_WRITE, // 1 write, 0 read
	input wire logic REQ_BYTE, // byte-wide access
	input wire logic REQ_STACK, // stack or register-bank access
	input wire logic REQ_BITOP, // single-bit access
	input wire logic FLASH_BANK2_BUSY, // write running in bank 2
	input wire logic FLASH_BANK3_BUSY, // write running in bank 3
	input wire logic FLASH_PE_REQ, // program/erase start request
	output logic [11:0] TARGET_SEL, // one-hot target of taken access
	output logic [1:0] WAIT_STATES, // waitstates for taken access
	output logic EXT_CYCLE, // external bus cycle start
	output logic ACCESS_ERROR, // access refused
	output logic [2:0] FLASH_BLOCK, // block index within flash
	output logic FLASH_BANK3, // block lies in bank 3
	output logic FLASH_PE_ALLOW, // program/erase permitted
	output logic [3:0] SEG_LINES, // usable segment address lines
	output logic [11:0] UNIT_VISIBLE // enabled regions, same order as target
);
	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		logic [11:0] tgt;
		logic [1:0] ws;
		logic ext;
		logic err;
		logic [2:0] blk;
		logic bank3;
		logic pe_ok;
		logic [3:0] seg;
		logic [11:0] vis;
	} obrd_state_t;

	obrd_state_t state_r;
	obrd_state_t state_nxt;

	logic glob;
	logic [15:0] pen;
	logic [11:0] hit;
	logic [11:0] en;
	logic onchip;
	logic in_flash;
	logic in_ctrl;
	logic in_rsv;
	logic rsv_on;
	logic [ADDR_W-1:0] fl_off;
	logic [2:0] blk;
	logic in_b3;
	logic bank_busy;
	logic is_ram;
	logic is_per;

	assign glob = SYSTEM_CONFIG_REG[obrd_pkg::SYS_GLOBAL_EN_BIT];
	assign pen = PERIPH_ENABLE_CONFIG_REG;

	// ***************************************************************
	// region match and enables
	// ***************************************************************
	function automatic logic in_rng(input logic [ADDR_W-1:0] a, input logic [23:0] lo,
			input logic [23:0] hi);
		in_rng = (a >= ADDR_W'(lo)) && (a <= ADDR_W'(hi));
	endfunction : in_rng

	// bit 0 of the vectors is the external interface, so it has no hit or enable
	always_comb begin
		hit = '0;
		hit[1] = in_rng(REQ_ADDR, obrd_pkg::FLASH_LO, obrd_pkg::FLASH_HI);
		hit[2] = in_rng(REQ_ADDR, obrd_pkg::SMALL_EXTENSION_RAM_LO, obrd_pkg::SMALL_EXTENSION_RAM_HI);
		hit[3] = in_rng(REQ_ADDR, obrd_pkg::LARGE_EXTENSION_RAM_LO, obrd_pkg::LARGE_EXTENSION_RAM_HI);
		hit[4] = in_rng(REQ_ADDR, obrd_pkg::FIRST_CAN_CONTROLLER_LO, obrd_pkg::FIRST_CAN_CONTROLLER_HI);
		hit[5] = in_rng(REQ_ADDR, obrd_pkg::SECOND_CAN_CONTROLLER_LO, obrd_pkg::SECOND_CAN_CONTROLLER_HI);
		hit[6] = in_rng(REQ_ADDR, obrd_pkg::RTC_LO, obrd_pkg::RTC_HI);
		hit[7] = in_rng(REQ_ADDR, obrd_pkg::PWM_LO, obrd_pkg::PWM_HI);
		hit[8] = in_rng(REQ_ADDR, obrd_pkg::ASC_LO, obrd_pkg::ASC_HI);
		hit[9] = in_rng(REQ_ADDR, obrd_pkg::SSC_LO, obrd_pkg::SSC_HI);
		hit[10] = in_rng(REQ_ADDR, obrd_pkg::I2C_LO, obrd_pkg::I2C_HI);
		hit[11] = in_rng(REQ_ADDR, obrd_pkg::TMR_LO, obrd_pkg::TMR_HI);
	end

	// every unit needs the global enable and its own bit
	always_comb begin
		en = '0;
		en[1] = glob && pen[obrd_pkg::PER_FLASH_BIT]; // [R1] [R2]
		en[2] = glob && pen[obrd_pkg::PER_SMALL_EXTENSION_RAM_BIT]; // [R9]
		en[3] = glob && pen[obrd_pkg::PER_LARGE_EXTENSION_RAM_BIT]; // [R10] [R11]
		en[4] = glob && pen[obrd_pkg::PER_FIRST_CAN_CONTROLLER_BIT]; // [R13] [R23]
		en[5] = glob && pen[obrd_pkg::PER_SECOND_CAN_CONTROLLER_BIT]; // [R14] [R23]
		en[6] = glob && pen[obrd_pkg::PER_RTC_BIT]; // [R15] [R23]
		en[7] = glob && pen[obrd_pkg::PER_PWM_BIT]; // [R16] [R23]
		en[8] = glob && pen[obrd_pkg::PER_ASC_BIT]; // [R17] [R23]
		en[9] = glob && pen[obrd_pkg::PER_SSC_BIT]; // [R18] [R23]
		en[10] = glob && pen[obrd_pkg::PER_I2C_BIT]; // [R19] [R23]
		en[11] = glob && pen[obrd_pkg::PER_TMR_BIT]; // [R20] [R23]
	end

	// ***************************************************************
	// flash geometry and reserved window
	// ***************************************************************
	// 64 Kbyte blocks: the segment number above the flash base picks the block
	assign in_flash = hit[1];
	assign fl_off = REQ_ADDR - ADDR_W'(obrd_pkg::FLASH_LO);
	assign blk = fl_off[18:16]; // [R4]
	assign in_ctrl = in_rng(REQ_ADDR, obrd_pkg::FCTRL_LO, obrd_pkg::FLASH_HI); // [R3]
	assign in_b3 = REQ_ADDR >= ADDR_W'(obrd_pkg::BANK3_LO); // [R4]
	assign bank_busy = in_b3 ? FLASH_BANK3_BUSY : FLASH_BANK2_BUSY;
	assign in_rsv = in_rng(REQ_ADDR, obrd_pkg::RSV_LO, obrd_pkg::RSV_HI);
	assign rsv_on = glob && (pen[obrd_pkg::PER_FLASH_BIT] || pen[obrd_pkg::PER_LARGE_EXTENSION_RAM_BIT]); // [R7]
	assign onchip = |(hit & en);
	assign is_ram = (hit[2] && en[2]) || (hit[3] && en[3]);
	assign is_per = |(hit[11:4] & en[11:4]);

	// ***************************************************************
	// next-state decode
	// ***************************************************************
	// refused accesses go nowhere, so a faulty request never reaches a pin
	always_comb begin
		state_nxt = state_r;
		state_nxt.tgt = obrd_pkg::OBRD_TGT_NONE;
		state_nxt.ws = obrd_pkg::WS_MEM;
		state_nxt.ext = 1'b0;
		state_nxt.err = 1'b0;
		state_nxt.blk = '0;
		state_nxt.bank3 = 1'b0;
		state_nxt.vis = en;
		state_nxt.vis[0] = 1'b1;
		state_nxt.pe_ok = en[1]; // [R3]
		state_nxt.seg = (en[4] || en[5]) ? 4'(obrd_pkg::SEG_LINES_CAN)
			: 4'(obrd_pkg::SEG_LINES_FULL); // [R22]
		if (REQ_VALID) begin
			if (onchip && is_ram && (REQ_STACK || REQ_BITOP)) begin
				state_nxt.err = 1'b1; // [R12]
			end else if (onchip && is_per && REQ_BYTE) begin
				state_nxt.err = 1'b1; // [R21]
			end else if (onchip && in_flash && !REQ_WRITE && !in_ctrl && bank_busy) begin
				state_nxt.err = 1'b1; // [R5]
			end else if (onchip) begin
				state_nxt.tgt = hit & en; // [R24]
				state_nxt.ws = is_per ? obrd_pkg::WS_PERIPH : obrd_pkg::WS_MEM; // [R8] [R21]
				state_nxt.blk = in_ctrl ? 3'h5 : blk;
				state_nxt.bank3 = in_flash && in_b3;
			end else if (in_rsv && rsv_on) begin
				state_nxt.err = 1'b1; // [R7]
			end else begin
				state_nxt.tgt = obrd_pkg::OBRD_TGT_EXT; // [R2] [R9] [R11]
				state_nxt.ext = 1'b1;
			end
		end
	end

	// ***************************************************************
	// state register
	// ***************************************************************
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs straight from the state flops, except FLASH_PE_ALLOW, which is gated by FLASH_PE_REQ
	assign TARGET_SEL = state_r.tgt;
	assign WAIT_STATES = state_r.ws;
	assign EXT_CYCLE = state_r.ext;
	assign ACCESS_ERROR = state_r.err;
	assign FLASH_BLOCK = state_r.blk;
	assign FLASH_BANK3 = state_r.bank3;
	assign FLASH_PE_ALLOW = state_r.pe_ok && FLASH_PE_REQ; // [R3]
	assign SEG_LINES = state_r.seg;
	assign UNIT_VISIBLE = state_r.vis;

	// ***************************************************************
	// checks
	// ***************************************************************
	one_target_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R24]
		$onehot0(TARGET_SEL) && !(EXT_CYCLE && TARGET_SEL != 12'h001))
		else $error("more than one target or stray external cycle");

	flash_en_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R1]
		TARGET_SEL[1] |-> $past(glob && pen[obrd_pkg::PER_FLASH_BIT]))
		else $error("flash selected while disabled");

	flash_off_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R2]
		REQ_VALID && !glob && in_flash |=> EXT_CYCLE)
		else $error("flash range not sent external");

	pe_gate_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R3]
		FLASH_PE_ALLOW |-> $past(en[1]))
		else $error("program allowed without control registers");

	block_idx_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R4]
		REQ_VALID && en[1] && REQ_WRITE && REQ_ADDR[23:16] == 8'h0D
		|=> FLASH_BLOCK == 3'h4 && FLASH_BANK3)
		else $error("wrong flash block or bank");

	rww_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R5]
		REQ_VALID && en[1] && !REQ_WRITE && in_flash && !in_ctrl && bank_busy
		|=> ACCESS_ERROR && !TARGET_SEL[1])
		else $error("read in busy bank");

	rsv_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R7]
		REQ_VALID && in_rsv && rsv_on |=> !EXT_CYCLE)
		else $error("external access in reserved window");

	per_ws_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R21]
		(|TARGET_SEL[11:4]) |-> WAIT_STATES == 2'h2)
		else $error("peripheral waitstates wrong");

	ram_ws_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R8]
		(TARGET_SEL[2] || TARGET_SEL[3]) |-> WAIT_STATES == 2'h0)
		else $error("ram waitstates wrong");

	seg_can_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R22]
		glob && (pen[0] || pen[1]) |=> SEG_LINES == 4'h4)
		else $error("segment lines not limited");

	ram_bit_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R12]
		REQ_VALID && is_ram && REQ_BITOP |=> ACCESS_ERROR)
		else $error("bit access to extension ram");

	small_extension_ram_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R9]
		REQ_VALID && hit[2] && !en[2] |=> EXT_CYCLE)
		else $error("small ram range not forwarded");

	// each window is read straight from the config words, so a crossed enable bit shows up
	large_extension_ram_on_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R10]
		REQ_VALID && !REQ_STACK && !REQ_BITOP && glob && pen[obrd_pkg::PER_LARGE_EXTENSION_RAM_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::LARGE_EXTENSION_RAM_LO, obrd_pkg::LARGE_EXTENSION_RAM_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_LARGE_EXTENSION_RAM)
		else $error("large ram not selected");

	large_extension_ram_off_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R11]
		REQ_VALID && !(glob && pen[obrd_pkg::PER_LARGE_EXTENSION_RAM_BIT])
		&& in_rng(REQ_ADDR, obrd_pkg::LARGE_EXTENSION_RAM_LO, obrd_pkg::LARGE_EXTENSION_RAM_HI) |=> EXT_CYCLE)
		else $error("large ram range not forwarded");

	first_can_controller_sel_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R13]
		REQ_VALID && !REQ_BYTE && glob && pen[obrd_pkg::PER_FIRST_CAN_CONTROLLER_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::FIRST_CAN_CONTROLLER_LO, obrd_pkg::FIRST_CAN_CONTROLLER_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_FIRST_CAN_CONTROLLER)
		else $error("first can not selected");

	second_can_controller_sel_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R14]
		REQ_VALID && !REQ_BYTE && glob && pen[obrd_pkg::PER_SECOND_CAN_CONTROLLER_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::SECOND_CAN_CONTROLLER_LO, obrd_pkg::SECOND_CAN_CONTROLLER_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_SECOND_CAN_CONTROLLER)
		else $error("second can not selected");

	rtc_sel_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R15]
		REQ_VALID && !REQ_BYTE && glob && pen[obrd_pkg::PER_RTC_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::RTC_LO, obrd_pkg::RTC_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_RTC)
		else $error("rtc not selected");

	pwm_sel_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R16]
		REQ_VALID && !REQ_BYTE && glob && pen[obrd_pkg::PER_PWM_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::PWM_LO, obrd_pkg::PWM_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_PWM)
		else $error("extra pwm not selected");

	asc_sel_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R17]
		REQ_VALID && !REQ_BYTE && glob && pen[obrd_pkg::PER_ASC_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::ASC_LO, obrd_pkg::ASC_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_ASC)
		else $error("async serial not selected");

	ssc_sel_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R18]
		REQ_VALID && !REQ_BYTE && glob && pen[obrd_pkg::PER_SSC_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::SSC_LO, obrd_pkg::SSC_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_SSC)
		else $error("sync serial not selected");

	i2c_sel_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R19]
		REQ_VALID && !REQ_BYTE && glob && pen[obrd_pkg::PER_I2C_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::I2C_LO, obrd_pkg::I2C_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_I2C)
		else $error("i2c not selected");

	tmr_sel_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R20]
		REQ_VALID && !REQ_BYTE && glob && pen[obrd_pkg::PER_TMR_BIT]
		&& in_rng(REQ_ADDR, obrd_pkg::TMR_LO, obrd_pkg::TMR_HI)
		|=> TARGET_SEL == obrd_pkg::OBRD_TGT_TMR)
		else $error("timer and misc not selected");

	// a hidden unit must not even refuse: its window belongs to the external bus
	per_hidden_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R23]
		REQ_VALID && (|(hit[11:4] & ~en[11:4])) |=> EXT_CYCLE && !ACCESS_ERROR)
		else $error("disabled peripheral still occupies its window");

	ram_stack_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R12]
		REQ_VALID && is_ram && REQ_STACK |=> ACCESS_ERROR && TARGET_SEL == 12'h000)
		else $error("stack access to extension ram");

	ram_byte_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R8]
		REQ_VALID && is_ram && REQ_BYTE && !REQ_STACK && !REQ_BITOP
		|=> !ACCESS_ERROR && (TARGET_SEL[2] || TARGET_SEL[3]))
		else $error("byte access to extension ram refused");

	per_byte_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R21]
		REQ_VALID && is_per && REQ_BYTE |=> ACCESS_ERROR && TARGET_SEL == 12'h000)
		else $error("byte access to peripheral taken");

	// no disable here: the cycle after a reset edge is exactly what it watches
	reset_clear_a: assert property (@(posedge CLK) !RESETN // [R24]
		|=> TARGET_SEL == 12'h000 && !EXT_CYCLE && !ACCESS_ERROR && UNIT_VISIBLE == 12'h000)
		else $error("outputs not cleared by reset");

	seg_full_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R22]
		!(glob && (pen[0] || pen[1])) |=> SEG_LINES == 4'h8)
		else $error("segment lines limited without can");

	onchip_ext_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R24]
		REQ_VALID && onchip |=> !EXT_CYCLE)
		else $error("external cycle beside on-chip hit");

	pe_block_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R3]
		!en[1] |=> !FLASH_PE_ALLOW)
		else $error("program allowed with control page hidden");

	bank2_idx_a: assert property (@(posedge CLK) disable iff (!RESETN) // [R4]
		REQ_VALID && en[1] && REQ_WRITE && REQ_ADDR[23:16] == 8'h09
		|=> FLASH_BLOCK == 3'h0 && !FLASH_BANK3)
		else $error("wrong bank 2 block");
endmodule : obrd_decoder

// ---- test/obrd_cpu_model.sv ----
`timescale 1ns/1ps
// ***************************************************************
// cpu core acting as master of the on-chip bus
// ***************************************************************
module obrd_cpu_model #(
	parameter int CLK_MHZ = 40 // cpu clock the software was set up for
) (
	input wire logic clk, // cpu clock
	output logic req_valid, // access request
	output logic [23:0] req_addr, // byte address
	output logic req_write, // write when high
	output logic req_byte, // byte-wide access
	output logic req_stack, // stack or register-bank access
	output logic req_bitop // single-bit access
);
	// software programs one flash waitstate only above the threshold clock
	localparam logic [1:0] FLASH_WS =
		(CLK_MHZ > obrd_pkg::FLASH_WS_FREQ_MHZ) ? 2'h1 : 2'h0;

	// idle at time zero, on a pattern that no region uses
	initial begin
		req_valid = 1'b0;
		req_addr = 24'hA5A5A5;
		req_write = 1'b0;
		req_byte = 1'b0;
		req_stack = 1'b0;
		req_bitop = 1'b0;
	end

	// caller stands just past an edge; the request is held up to the next edge
	task automatic issue(input logic [23:0] a, input logic w, by, st, bo);
		req_valid = 1'b1;
		req_addr = a;
		req_write = w;
		req_byte = by;
		req_stack = st;
		req_bitop = bo;
		@(posedge clk);
		#1;
	endtask : issue

	// released lines show the inverse of the last value, so nothing stale looks valid
	task automatic idle();
		req_valid = 1'b0;
		req_addr = ~req_addr;
		req_write = ~req_write;
		req_byte = ~req_byte;
		req_stack = ~req_stack;
		req_bitop = ~req_bitop;
	endtask : idle
endmodule : obrd_cpu_model

// ---- test/tb_onchip_bus_region_decoder.sv ----
`timescale 1ns/1ps
module tb_onchip_bus_region_decoder;
	// ***************************************************************
	// peripheral windows, in target-select order from bit 4 up
	// ***************************************************************
	localparam logic [23:0] PLO [8] = '{obrd_pkg::FIRST_CAN_CONTROLLER_LO, obrd_pkg::SECOND_CAN_CONTROLLER_LO, obrd_pkg::RTC_LO,
		obrd_pkg::PWM_LO, obrd_pkg::ASC_LO, obrd_pkg::SSC_LO, obrd_pkg::I2C_LO, obrd_pkg::TMR_LO};
	localparam logic [23:0] PHI [8] = '{obrd_pkg::FIRST_CAN_CONTROLLER_HI, obrd_pkg::SECOND_CAN_CONTROLLER_HI, obrd_pkg::RTC_HI,
		obrd_pkg::PWM_HI, obrd_pkg::ASC_HI, obrd_pkg::SSC_HI, obrd_pkg::I2C_HI, obrd_pkg::TMR_HI};
	localparam int PBIT [8] = '{0, 1, 4, 6, 7, 8, 9, 10};
	localparam logic [23:0] ADDRS [24] = '{24'h090000, 24'h0A8000, 24'h0BFFFF, 24'h0C0000,
		24'h0DFFFF, 24'h0E0000, 24'h0EFFFF, 24'h080000, 24'h08FFFF, 24'h00E000, 24'h00E7FF,
		24'h0F0000, 24'h0FFFFF, 24'h00EF00, 24'h00EEFF, 24'h00ED00, 24'h00ECFF, 24'h00E900,
		24'h00E8FF, 24'h00EA00, 24'h00EB7F, 24'h00EB80, 24'h00DFFF, 24'h100000};
	localparam logic [15:0] SYSV [6] = '{16'h0004, 16'h0000, 16'h0004, 16'h0004, 16'h0004, 16'h0004};
	localparam logic [15:0] PERV [6] = '{16'h07FF, 16'h07FF, 16'h0000, 16'h0555, 16'h02AA, 16'h0008};
	logic clk, resetn, b2_busy, b3_busy, pe_req, valid, wr, by, st, bo, ext_cyc, err, bank3, pe_ok;
	logic [15:0] sys_cfg, pen;
	logic [23:0] addr;
	logic [11:0] tsel, visible;
	logic [1:0] ws;
	logic [2:0] blk;
	logic [3:0] seg;
	int error_cnt, samples_checked, cyc;

	// clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	obrd_cpu_model u_cpu (.clk(clk), .req_valid(valid), .req_addr(addr), .req_write(wr),
		.req_byte(by), .req_stack(st), .req_bitop(bo));
	obrd_decoder u_dut (.CLK(clk), .RESETN(resetn), .SYSTEM_CONFIG_REG(sys_cfg),
		.PERIPH_ENABLE_CONFIG_REG(pen), .REQ_VALID(valid), .REQ_ADDR(addr), .REQ_WRITE(wr),
		.REQ_BYTE(by), .REQ_STACK(st), .REQ_BITOP(bo), .FLASH_BANK2_BUSY(b2_busy),
		.FLASH_BANK3_BUSY(b3_busy), .FLASH_PE_REQ(pe_req), .TARGET_SEL(tsel), .WAIT_STATES(ws),
		.EXT_CYCLE(ext_cyc), .ACCESS_ERROR(err), .FLASH_BLOCK(blk), .FLASH_BANK3(bank3),
		.FLASH_PE_ALLOW(pe_ok), .SEG_LINES(seg), .UNIT_VISIBLE(visible));

	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// reference answer: {refused, waitstates, one-hot target}
	function automatic logic [14:0] expect_resp(input logic [23:0] a, input logic w, by, st, bo);
		logic g;
		logic [11:0] t;
		logic e;
		g = sys_cfg[2];
		t = 12'h001;
		if (g && pen[5] && a >= obrd_pkg::FLASH_LO && a <= obrd_pkg::FLASH_HI) t = 12'h002;
		if (g && pen[2] && a >= obrd_pkg::SMALL_EXTENSION_RAM_LO && a <= obrd_pkg::SMALL_EXTENSION_RAM_HI) t = 12'h004;
		if (g && pen[3] && a >= obrd_pkg::LARGE_EXTENSION_RAM_LO && a <= obrd_pkg::LARGE_EXTENSION_RAM_HI) t = 12'h008;
		for (int i = 0; i < 8; i++) begin
			if (g && pen[PBIT[i]] && a >= PLO[i] && a <= PHI[i]) t = 12'h010 << i;
		end
		e = ((t[2] | t[3]) && (st || bo)) || ((|t[11:4]) && by);
		e = e || (t[1] && !w && a < obrd_pkg::FCTRL_LO && (a >= obrd_pkg::BANK3_LO ? b3_busy : b2_busy));
		e = e || (t == 12'h001 && g && (pen[5] | pen[3]) && a >= obrd_pkg::RSV_LO && a <= obrd_pkg::RSV_HI);
		return {e, (|t[11:4]) ? obrd_pkg::WS_PERIPH : obrd_pkg::WS_MEM, e ? 12'h000 : t};
	endfunction : expect_resp

	// one access through the cpu model, answer looked at in the cycle it stands
	task automatic acc(input logic [23:0] a, input logic w, by, st, bo);
		logic [14:0] e;
		logic [23:0] off;
		e = expect_resp(a, w, by, st, bo);
		off = a - obrd_pkg::FLASH_LO;
		u_cpu.issue(a, w, by, st, bo);
		chk("target", e[11:0], tsel);
		chk("refused", 12'(e[14]), 12'(err));
		chk("external", 12'(e[11:0] == 12'h001), 12'(ext_cyc));
		if (!e[14]) chk("waits", 12'(e[13:12]), 12'(ws));
		if (e[1]) chk("flash waits", 12'(u_cpu.FLASH_WS), 12'(ws));
		if (e[1]) chk("block", 12'(off[18:16]), 12'(blk));
		if (e[1]) chk("bank3", 12'(a >= obrd_pkg::BANK3_LO), 12'(bank3));
	endtask : acc

	// new enables, then one settled cycle for the registered views of them
	task automatic cfg(input logic [15:0] s, input logic [15:0] p);
		logic [11:0] v;
		u_cpu.idle();
		sys_cfg = s;
		pen = p;
		@(posedge clk);
		#1;
		v = {p[10], p[9], p[8], p[7], p[6], p[4], p[1], p[0], p[3], p[2], p[5], 1'b0};
		chk("visible", (s[2] ? v : 12'h000) | 12'h001, visible);
		chk("seglines", (s[2] && (p[0] || p[1])) ? 12'h004 : 12'h008, 12'(seg));
		chk("pe_allow", 12'(s[2] & p[5]), 12'(pe_ok));
	endtask : cfg

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			test_done();
		end
	end

	initial begin
		error_cnt = 0;
		samples_checked = 0;
		cyc = 0;
		resetn = 1'b0;
		sys_cfg = 16'h0000;
		pen = 16'h0000;
		b2_busy = 1'b0;
		b3_busy = 1'b0;
		pe_req = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		resetn = 1'b1;
		// the six enable patterns against both edges of each memory window and one edge of each peripheral window, accesses back to back
		for (int c = 0; c < 6; c++) begin
			cfg(SYSV[c], PERV[c]);
			foreach (ADDRS[i]) acc(ADDRS[i], 1'b0, 1'b0, 1'b0, 1'b0);
		end
		$display("test address map done");
		// width and kind of access against memories and peripherals
		cfg(16'h0004, 16'h07FF);
		for (int k = 0; k < 8; k++) begin
			acc(24'h00E010, k[0], k[1], k[2], 1'b0);
			acc(24'h0F0100, k[0], 1'b0, 1'b0, k[2]);
			acc(24'h00EF02, k[0], k[1], 1'b0, 1'b0);
			acc(24'h00EB10, k[0], k[2], 1'b0, 1'b0);
			acc(24'h0A0001, k[0], k[1], 1'b0, 1'b0);
		end
		$display("test access kinds done");
		// a write running in one bank blocks reads there only
		b2_busy = 1'b1;
		foreach (ADDRS[i]) acc(ADDRS[i], 1'b0, 1'b0, 1'b0, 1'b0);
		acc(24'h090010, 1'b1, 1'b0, 1'b0, 1'b0);
		b2_busy = 1'b0;
		b3_busy = 1'b1;
		foreach (ADDRS[i]) acc(ADDRS[i], 1'b0, 1'b0, 1'b0, 1'b0);
		acc(24'h0D0010, 1'b1, 1'b0, 1'b0, 1'b0);
		b3_busy = 1'b0;
		$display("test flash banks done");
		// a taken access stands one cycle only; a dropped request blocks programming
		pe_req = 1'b0;
		u_cpu.idle();
		@(posedge clk);
		#1;
		chk("target", 12'h000, tsel);
		chk("external", 12'h000, 12'(ext_cyc));
		chk("pe_allow", 12'h000, 12'(pe_ok));
		pe_req = 1'b1;
		$display("test release done");
		// a reset in mid-run clears every registered view, a request meanwhile is lost
		resetn = 1'b0;
		u_cpu.issue(24'h00EF00, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("target", 12'h000, tsel);
		chk("visible", 12'h000, visible);
		chk("seglines", 12'h000, 12'(seg));
		resetn = 1'b1;
		cfg(16'h0004, 16'h07FF);
		acc(24'h00EF00, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("test reset done");
		test_done();
	end
endmodule : tb_onchip_bus_region_decoder
